// ==== logic/fesp_ctrl.sv ====
// Contract
// - sector erase: six writes, last carries 30h with sector address
// - block erase: six writes, last carries 50h with block address
// - chip erase: six writes ending 10h at 5555h, array to ones
// - host only reads status bits from flash while erase runs
// - apparent completion is confirmed by two further matching reads
// - program needs four write cycles, erase six cycles
// - exit sequence returns device from id mode to array reads
`timescale 1ns/1ps
module fesp_ctrl
  import fesp_pkg::*;
#(
  parameter int ERASE_TIMEOUT_CYC = 1000000,
  parameter int PROG_TIMEOUT_CYC  = PROG_CYC + 64
) (
  input  wire logic          i_clk,
  input  wire logic          i_srst,
  input  wire logic          i_cmd_valid,
  input  wire fesp_op_t      i_cmd_op,
  input  wire logic [19:0]   i_cmd_addr,
  input  wire logic [15:0]   i_cmd_wdata,
  output logic               o_busy,
  output logic               o_done,
  output logic               o_error,
  output logic [15:0]        o_rdata,
  output logic               o_id_mode,
  output logic [19:0]        o_addr,
  output logic [15:0]        o_dq_out,
  output logic               o_dq_oe_n,
  input  wire logic [15:0]   i_dq_in,
  output logic               o_flash_bank_sel_n,
  output logic               o_sram_bank_sel_n,
  output logic               o_oe_n,
  output logic               o_we_n
);

  typedef struct packed {
    fesp_state_t state;
    fesp_op_t    op;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic [2:0]  idx;
    logic [3:0]  wait_cnt;
    logic [19:0] timer;
    logic        polling;
    logic        have_prev;
    logic        prev_tgl;
    logic [1:0]  stable;
    logic        busy;
    logic        done;
    logic        error;
    logic        id_mode;
    logic [15:0] rdata;
    fesp_pins_t  pins;
  } fesp_ctrl_st_t;

  localparam fesp_pins_t PINS_IDLE = '{addr: 20'h00000, dq_out: 16'h0000, dq_oe_n: 1'b1,
                                       flash_bank_sel_n: 1'b1, sram_bank_sel_n: 1'b1,
                                       oe_n: 1'b1, we_n: 1'b1};

  fesp_ctrl_st_t st_r;
  fesp_ctrl_st_t st_nxt;
  logic [15:0]   dq_sync;

  fesp_sync #(.W(16)) u_dq_sync (
    .i_clk (i_clk),
    .i_srst(i_srst),
    .i_d   (i_dq_in),
    .o_q   (dq_sync)
  );

  // ----------------------------------------------------------------------
  // sequence decode
  // ----------------------------------------------------------------------
  function automatic logic [2:0] seq_len(input fesp_op_t op);
    case (op)
      OP_PROG:                                     seq_len = LEN_PROG;
      OP_SECT_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE: seq_len = LEN_ERASE;
      OP_ID_ENTRY, OP_ID_EXIT:                     seq_len = LEN_ID;
      default:                                     seq_len = 3'h0;
    endcase
  endfunction : seq_len

  function automatic fesp_word_t seq_word(input fesp_op_t op, input logic [2:0] idx,
                                          input logic [19:0] a, input logic [15:0] d);
    fesp_word_t w;
    w = '{addr: UNLK_ADDR_A, data: UNLK_DATA_A};
    case (idx)
      3'h1, 3'h4: w = '{addr: UNLK_ADDR_B, data: UNLK_DATA_B};
      3'h2: begin
        case (op)
          OP_PROG:     w.data = CMD_PROGRAM;
          OP_ID_ENTRY: w.data = CMD_ID_ENTRY;
          OP_ID_EXIT:  w.data = CMD_ID_EXIT;
          default:     w.data = CMD_ERASE_SETUP;
        endcase
      end
      3'h3: if (op == OP_PROG) begin
        w = '{addr: a, data: d};
      end
      3'h5: begin
        case (op)
          OP_SECT_ERASE:  w = '{addr: {a[19:SECT_LSB], 11'h000},
                                data: CMD_SECT_ERASE};
          OP_BLOCK_ERASE: w = '{addr: {a[19:BLOCK_LSB], 15'h0000},
                                data: CMD_BLOCK_ERASE};
          default:        w = '{addr: UNLK_ADDR_A, data: CMD_CHIP_ERASE};
        endcase
      end
      // only valid cycles are ever built, so no sequence is aborted
      default: w = '{addr: UNLK_ADDR_A, data: UNLK_DATA_A};
    endcase
    return w;
  endfunction : seq_word

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    fesp_word_t w;
    logic       tgl;
    logic       conf;
    w      = seq_word(st_r.op, st_r.idx, st_r.addr, st_r.wdata);
    tgl    = dq_sync[TOGGLE_STATUS_BIT];
    conf   = 1'b0;
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (st_r.polling) begin
      st_nxt.timer = st_r.timer + 20'h00001;
    end
    case (st_r.state)
      ST_IDLE: begin
        // commands arrive only here, so nothing reaches a busy device
        if (i_cmd_valid) begin
          st_nxt.op        = i_cmd_op;
          st_nxt.addr      = i_cmd_addr;
          st_nxt.wdata     = i_cmd_wdata;
          st_nxt.idx       = 3'h0;
          st_nxt.timer     = 20'h00000;
          st_nxt.stable    = 2'h0;
          st_nxt.have_prev = 1'b0;
          st_nxt.error     = 1'b0;
          st_nxt.busy      = 1'b1;
          st_nxt.pins.addr = i_cmd_addr;
          st_nxt.state     = (i_cmd_op == OP_READ) ? ST_RD_SET : ST_WR_SET;
        end
      end
      ST_WR_SET: begin
        // strobe falls on the same clock edge that drives address and data, gate held high
        st_nxt.pins.addr             = w.addr;
        st_nxt.pins.dq_out           = w.data;
        st_nxt.pins.dq_oe_n          = 1'b0;
        st_nxt.pins.oe_n             = 1'b1;
        st_nxt.pins.we_n             = 1'b0;
        st_nxt.pins.flash_bank_sel_n = 1'b0;
        st_nxt.state                 = ST_WR_STB;
      end
      ST_WR_STB: begin
        // one full clock low, far above the glitch filter
        // rising edge latches the code, erase starts after it
        st_nxt.pins.we_n             = 1'b1;
        st_nxt.pins.flash_bank_sel_n = 1'b1;
        st_nxt.state                 = ST_WR_HOLD;
      end
      ST_WR_HOLD: begin
        st_nxt.pins.dq_oe_n = 1'b1;
        st_nxt.idx          = st_r.idx + 3'h1;
        if (st_r.idx + 3'h1 != seq_len(st_r.op)) begin
          st_nxt.state = ST_WR_SET;
        end else if (st_r.op == OP_ID_ENTRY || st_r.op == OP_ID_EXIT) begin
          st_nxt.id_mode = (st_r.op == OP_ID_ENTRY);
          st_nxt.busy    = 1'b0;
          st_nxt.done    = 1'b1;
          st_nxt.state   = ST_IDLE;
        end else begin
          // polling only after the last strobe has risen
          st_nxt.polling   = 1'b1;
          st_nxt.pins.addr = (st_r.op == OP_PROG) ? st_r.addr : w.addr;
          st_nxt.state     = ST_RD_SET;
        end
      end
      ST_RD_SET: begin
        st_nxt.pins.oe_n             = 1'b0;
        st_nxt.pins.flash_bank_sel_n = 1'b0;
        st_nxt.wait_cnt              = READ_WAIT_CYC;
        st_nxt.state                 = ST_RD_WAIT;
      end
      ST_RD_WAIT: begin
        st_nxt.wait_cnt = st_r.wait_cnt - 4'h1;
        if (st_r.wait_cnt == 4'h1) begin
          st_nxt.pins.oe_n             = 1'b1;
          st_nxt.pins.flash_bank_sel_n = 1'b1;
          st_nxt.rdata                 = dq_sync;
          st_nxt.state                 = ST_RD_SET;
          if (!st_r.polling) begin
            st_nxt.busy  = 1'b0;
            st_nxt.done  = 1'b1;
            st_nxt.state = ST_IDLE;
          end else begin
            // only status reads while busy; stop toggling counts as done
            st_nxt.have_prev = 1'b1;
            st_nxt.prev_tgl  = tgl;
            if (st_r.have_prev && tgl == st_r.prev_tgl) begin
              st_nxt.stable = st_r.stable + 2'h1;
              // first quiet pair plus two more quiet reads
              conf = (st_r.stable + 2'h1 == CONFIRM_READS);
            end else begin
              st_nxt.stable = 2'h0;
            end
            if (conf) begin
              // bit 7 must show true data or ones for erase
              st_nxt.error   = (st_r.op == OP_PROG) ?
                               (dq_sync[INV_STATUS_BIT] != st_r.wdata[INV_STATUS_BIT]) :
                               !dq_sync[INV_STATUS_BIT];
              st_nxt.polling = 1'b0;
              st_nxt.busy    = 1'b0;
              st_nxt.done    = 1'b1;
              st_nxt.state   = ST_IDLE;
            end else if (st_r.timer >= ((st_r.op == OP_PROG) ? 20'(PROG_TIMEOUT_CYC) :
                                                             20'(ERASE_TIMEOUT_CYC))) begin
              st_nxt.error   = 1'b1;
              st_nxt.polling = 1'b0;
              st_nxt.busy    = 1'b0;
              st_nxt.done    = 1'b1;
              st_nxt.state   = ST_IDLE;
            end
          end
        end
      end
      default: begin
        st_nxt       = st_r;
        st_nxt.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_r       <= '0;
      st_r.state <= ST_IDLE;
      st_r.op    <= OP_READ;
      st_r.pins  <= PINS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_busy             = st_r.busy;
  assign o_done             = st_r.done;
  assign o_error            = st_r.error;
  assign o_rdata            = st_r.rdata;
  assign o_id_mode          = st_r.id_mode;
  assign o_addr             = st_r.pins.addr;
  assign o_dq_out           = st_r.pins.dq_out;
  assign o_dq_oe_n          = st_r.pins.dq_oe_n;
  assign o_flash_bank_sel_n = st_r.pins.flash_bank_sel_n;
  assign o_sram_bank_sel_n  = st_r.pins.sram_bank_sel_n;
  assign o_oe_n             = st_r.pins.oe_n;
  assign o_we_n             = st_r.pins.we_n;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic [2:0] strobes_r;
  always_ff @(posedge i_clk) begin
    if (i_srst || st_r.state == ST_IDLE) begin
      strobes_r <= 3'h0;
    end else if (st_r.state == ST_WR_STB) begin
      strobes_r <= strobes_r + 3'h1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_write_gate_high: assert property (!o_we_n |-> o_oe_n && !o_flash_bank_sel_n)
    else $error("write strobe low with gate low or bank deselected");
  a_strobe_one_cycle: assert property ($fell(o_we_n) |=> $rose(o_we_n))
    else $error("write strobe not exactly one cycle");
  a_addr_data_held: assert property ($fell(o_we_n) |=> $stable(o_addr) && $stable(o_dq_out)
                                     && !o_dq_oe_n)
    else $error("address or data moved around strobe");
  a_erase_six_writes: assert property ($rose(st_r.polling) && st_r.op != OP_PROG
                                       |-> strobes_r == 3'h6)
    else $error("erase issued without six write cycles");
  a_prog_four_writes: assert property ($rose(st_r.polling) && st_r.op == OP_PROG
                                       |-> strobes_r == 3'h4)
    else $error("program issued without four write cycles");
  a_no_drive_on_read: assert property (!o_oe_n |-> o_dq_oe_n && o_we_n)
    else $error("host drives data during a read");
  a_busy_no_cmd: assert property (o_busy && st_r.state != ST_IDLE
                                  |=> $stable(st_r.op))
    else $error("command taken while busy");
  a_done_confirmed: assert property (o_done && $past(st_r.polling) && !o_error
                                     |-> $past(st_r.stable) == 2'h2)
    else $error("completion without two confirming reads");
  a_sram_idle: assert property (o_sram_bank_sel_n)
    else $error("sram bank selected by flash controller");
  a_chip_erase_addr: assert property (!o_we_n && st_r.op == OP_CHIP_ERASE && st_r.idx == 3'h5
                                      |-> o_addr == UNLK_ADDR_A
                                      && o_dq_out == CMD_CHIP_ERASE)
    else $error("chip erase final cycle wrong");

  c_program: cover property (o_done && st_r.op == OP_PROG && !o_error);
  c_sector:  cover property (o_done && st_r.op == OP_SECT_ERASE && !o_error);
  c_id:      cover property (o_done && st_r.op == OP_ID_ENTRY);
  c_timeout: cover property (o_done && o_error);

endmodule : fesp_ctrl

// ==== logic/fesp_pkg.sv ====
package fesp_pkg;

  // ----------------------------------------------------------------------
  // bus widths
  // ----------------------------------------------------------------------
  localparam int          FESP_AW          = 20;
  localparam int          FESP_DW          = 16;

  // ----------------------------------------------------------------------
  // unlock cycles and command codes
  // ----------------------------------------------------------------------
  localparam logic [19:0] UNLK_ADDR_A      = 20'h05555;
  localparam logic [19:0] UNLK_ADDR_B      = 20'h02aaa;
  localparam logic [15:0] UNLK_DATA_A      = 16'h00aa;
  localparam logic [15:0] UNLK_DATA_B      = 16'h0055;
  localparam logic [15:0] CMD_PROGRAM      = 16'h00a0;
  localparam logic [15:0] CMD_ERASE_SETUP  = 16'h0080;
  localparam logic [15:0] CMD_SECT_ERASE   = 16'h0030;
  localparam logic [15:0] CMD_BLOCK_ERASE  = 16'h0050;
  localparam logic [15:0] CMD_CHIP_ERASE   = 16'h0010;
  localparam logic [15:0] CMD_ID_ENTRY     = 16'h0090;
  localparam logic [15:0] CMD_ID_EXIT      = 16'h00f0;

  // ----------------------------------------------------------------------
  // field positions and sequence lengths
  // ----------------------------------------------------------------------
  localparam int          SECT_LSB         = 11;
  localparam int          BLOCK_LSB        = 15;
  localparam int          INV_STATUS_BIT   = 7;
  localparam int          TOGGLE_STATUS_BIT = 6;
  localparam logic [2:0]  LEN_PROG         = 3'h4;
  localparam logic [2:0]  LEN_ERASE        = 3'h6;
  localparam logic [2:0]  LEN_ID           = 3'h3;
  localparam logic [1:0]  CONFIRM_READS    = 2'h3;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS    = 100;
  localparam int          T_ACC_NS         = 90;
  localparam int          T_PROG_US        = 20;
  localparam int          SYNC_LAT_CYC     = 4;
  localparam logic [3:0]  READ_WAIT_CYC    =
    4'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT_CYC);
  localparam int          PROG_CYC         = T_PROG_US * 1000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ        = 3'h0,
    OP_PROG        = 3'h1,
    OP_SECT_ERASE  = 3'h2,
    OP_BLOCK_ERASE = 3'h3,
    OP_CHIP_ERASE  = 3'h4,
    OP_ID_ENTRY    = 3'h5,
    OP_ID_EXIT     = 3'h6
  } fesp_op_t;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_WR_SET  = 6'h02,
    ST_WR_STB  = 6'h04,
    ST_WR_HOLD = 6'h08,
    ST_RD_SET  = 6'h10,
    ST_RD_WAIT = 6'h20
  } fesp_state_t;

  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] data;
  } fesp_word_t;

  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] dq_out;
    logic        dq_oe_n;
    logic        flash_bank_sel_n;
    logic        sram_bank_sel_n;
    logic        oe_n;
    logic        we_n;
  } fesp_pins_t;

endpackage : fesp_pkg

// ==== logic/fesp_sync.sv ====
`timescale 1ns/1ps
module fesp_sync #(
  parameter int W = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } fesp_sync_st_t;

  fesp_sync_st_t st_r;
  fesp_sync_st_t st_nxt;

  // ----------------------------------------------------------------------
  // three stages; the output follows only where stages two and three agree
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = i_d;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_q = st_r.q;

endmodule : fesp_sync

// ==== tb/fesp_flash_model.sv ====
`timescale 1ns/1ps
module fesp_flash_model
  import fesp_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE = 16'h00c5, // arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h0a5a, // arbitrary value
  parameter real         PROG_NS    = 15000.0,
  parameter real         ERASE_NS   = 60000.0
) (
  input  wire logic [19:0] i_addr,
  input  wire logic [15:0] i_dq,
  input  wire logic        i_flash_bank_sel_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  output logic      [15:0] o_dq
);
  // ----------------------------------------------------------------
  // behavioural flash bank, no clock
  // ----------------------------------------------------------------
  logic [15:0] mem [int];
  logic [19:0] wa;
  logic [15:0] rd_q = 16'h0000;
  logic [15:0] last_d = 16'h0000;
  logic [2:0]  step = 3'h0;
  logic        erasing = 1'b0;
  logic        id_mode = 1'b0;
  logic        tgl = 1'b0;
  logic        armed = 1'b0;
  real         t_fall = 0.0;
  real         busy_end = 0.0;
  wire         wr_en = ~i_we_n & ~i_flash_bank_sel_n & i_oe_n;
  wire         rd_en = ~i_oe_n & ~i_flash_bank_sel_n & i_we_n;

  // released bus shows the inverse, so a stale value never passes
  assign o_dq = rd_en ? rd_q : ~rd_q;

  function automatic logic busy();
    return $realtime < busy_end;
  endfunction : busy

  task automatic cmd_cycle(input logic [19:0] a, input logic [15:0] d);
    int q [$];
    int lsb;
    logic [2:0] nxt;
    nxt = 3'h0;
    case (step)
      3'h0, 3'h3: nxt = (a == UNLK_ADDR_A && d == UNLK_DATA_A) ? step + 3'h1 : 3'h0;
      3'h1, 3'h4: nxt = (a == UNLK_ADDR_B && d == UNLK_DATA_B) ? step + 3'h1 : 3'h0;
      3'h2: begin
        if (a == UNLK_ADDR_A && d == CMD_PROGRAM) nxt = 3'h6;
        if (a == UNLK_ADDR_A && d == CMD_ERASE_SETUP) nxt = 3'h3;
        if (a == UNLK_ADDR_A && d == CMD_ID_ENTRY) id_mode = 1'b1;
        if (a == UNLK_ADDR_A && d == CMD_ID_EXIT) id_mode = 1'b0;
      end
      3'h5: begin
        lsb = (d == CMD_SECT_ERASE) ? SECT_LSB : (d == CMD_BLOCK_ERASE) ? BLOCK_LSB : FESP_AW;
        if (d == CMD_SECT_ERASE || d == CMD_BLOCK_ERASE ||
            (d == CMD_CHIP_ERASE && a == UNLK_ADDR_A)) begin
          foreach (mem[k]) if ((k >> lsb) == (int'(a) >> lsb)) q.push_back(k);
          foreach (q[i]) mem.delete(q[i]);
          erasing = 1'b1;
          busy_end = $realtime + ERASE_NS;
        end
      end
      3'h6: begin
        mem[int'(a)] = d;
        last_d = d;
        erasing = 1'b0;
        busy_end = $realtime + PROG_NS;
      end
      default: nxt = 3'h0;
    endcase
    step = nxt;
  endtask : cmd_cycle

  // address at the later fall of strobe and select, data at the earlier rise
  always @(posedge wr_en) begin
    wa = i_addr;
    t_fall = $realtime;
    armed = 1'b1;
  end

  // only a real low pulse counts; the unknown-to-low step at start-up does not
  always @(negedge wr_en) begin
    if (armed && $realtime - t_fall >= 5.0 && !busy()) begin
      cmd_cycle(wa, i_dq);
    end
    armed = 1'b0;
  end

  always @(posedge rd_en) begin
    if (busy()) begin
      tgl = ~tgl;
      rd_q = {8'h00, erasing ? 1'b0 : ~last_d[7], tgl, 6'h00};
    end else if (id_mode) begin
      rd_q = (i_addr == 20'h00000) ? MAKER_CODE :
             (i_addr == 20'h00001) ? PART_CODE : 16'h0000;
    end else begin
      rd_q = mem.exists(int'(i_addr)) ? mem[int'(i_addr)] : 16'hffff;
    end
  end
endmodule : fesp_flash_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
  import fesp_pkg::*;
;
  localparam logic [15:0] MAKER = 16'h00c5; // arbitrary value
  localparam logic [15:0] PART  = 16'h0a5a; // arbitrary value

  logic        i_clk;
  logic        i_srst;
  logic        cmd_valid;
  fesp_op_t    cmd_op;
  logic [19:0] cmd_addr;
  logic [19:0] p_addr;
  logic [15:0] cmd_wdata;
  logic [15:0] rdata;
  logic [15:0] dq_out;
  logic [15:0] mdl_dq;
  logic [15:0] dq_bus;
  logic        busy;
  logic        done;
  logic        error;
  logic        id_mode;
  logic        dq_oe_n;
  logic        fsel_n;
  logic        ssel_n;
  logic        oe_n;
  logic        we_n;
  int          n_errors;
  int          checked;
  int          cycles;

  assign dq_bus = dq_oe_n ? mdl_dq : dq_out;

  initial i_clk = 1'b0;
  always #50 i_clk = ~i_clk;

  fesp_ctrl #(.ERASE_TIMEOUT_CYC(2000)) u_fesp_ctrl (
    .i_clk(i_clk), .i_srst(i_srst), .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op),
    .i_cmd_addr(cmd_addr), .i_cmd_wdata(cmd_wdata), .o_busy(busy), .o_done(done),
    .o_error(error), .o_rdata(rdata), .o_id_mode(id_mode), .o_addr(p_addr),
    .o_dq_out(dq_out), .o_dq_oe_n(dq_oe_n), .i_dq_in(dq_bus),
    .o_flash_bank_sel_n(fsel_n), .o_sram_bank_sel_n(ssel_n), .o_oe_n(oe_n), .o_we_n(we_n));

  fesp_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_fesp_flash_model (
    .i_addr(p_addr), .i_dq(dq_bus), .i_flash_bank_sel_n(fsel_n), .i_oe_n(oe_n),
    .i_we_n(we_n), .o_dq(mdl_dq));

  task automatic stop_test();
    if (n_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [19:0] seen, input logic [19:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic run(input fesp_op_t op, input logic [19:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge i_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge i_clk);
    cmd_valid = 1'b0;
    chk("busy", busy, 20'h00001);
    while (done !== 1'b1 && n < 4000) begin
      @(negedge i_clk);
      n++;
    end
    chk("done", done, 20'h00001);
    chk("busy end", busy, 20'h00000);
  endtask : run

  task automatic wr(input fesp_op_t op, input logic [19:0] a, input logic [15:0] d);
    run(op, a, d);
    chk("error", error, 20'h00000);
  endtask : wr

  task automatic rd(input logic [19:0] a, input logic [15:0] exp);
    run(OP_READ, a, 16'h0000);
    chk("rdata", rdata, {4'h0, exp});
  endtask : rd

  // ----------------------------------------------------------------
  // write inhibit watch and run limit
  // ----------------------------------------------------------------
  always @(negedge i_clk) begin
    if (we_n === 1'b0) chk("oe_n in write", oe_n, 20'h00001);
  end

  // longest erase plus polls stays far below this ceiling
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    i_srst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_READ;
    cmd_addr = 20'h00000;
    cmd_wdata = 16'h0000;
    n_errors = 0;
    checked = 0;
    cycles = 0;
    repeat (16) @(negedge i_clk);
    chk("we_n reset", we_n, 20'h00001);
    i_srst = 1'b0;
    wr(OP_PROG, 20'h12345, 16'h1234);
    rd(20'h12345, 16'h1234);
    wr(OP_PROG, 20'h12b45, 16'h00c3);
    wr(OP_SECT_ERASE, 20'h12000, 16'h0000);
    rd(20'h12345, 16'hffff);
    rd(20'h12b45, 16'h00c3);
    wr(OP_PROG, 20'h27fff, 16'h5a5a);
    wr(OP_BLOCK_ERASE, 20'h20abc, 16'h0000);
    rd(20'h27fff, 16'hffff);
    rd(20'h12b45, 16'h00c3);
    wr(OP_CHIP_ERASE, 20'h00000, 16'h0000);
    rd(20'h12b45, 16'hffff);
    wr(OP_ID_ENTRY, 20'h00000, 16'h0000);
    chk("id_mode on", id_mode, 20'h00001);
    rd(20'h00000, MAKER);
    rd(20'h00001, PART);
    wr(OP_ID_EXIT, 20'h00000, 16'h0000);
    chk("id_mode off", id_mode, 20'h00000);
    rd(20'h00001, 16'hffff);
    chk("sram sel", ssel_n, 20'h00001);
    stop_test();
  end
endmodule : tb_top
